// file: rtl/dout_channels.sv
// dout_channels: eight digital output channels with mode, error strategy,
// inversion, ON/OFF delay and communication watchdog.
// assumes link inputs come from the communication unit logic on sys_clk.
//
// Contract
// RQ1: no line fault is ever detected or reported
// RQ2: three failed exchanges, then 500 ms, outputs off
// RQ3: channel active follows module-wide active setting
// RQ4: normal mode drives received bus value
// RQ5: simulation mode drives configured simulated value
// RQ6: watchdog, bus failure or invalid value start strategy
// RQ7: line faults never start the error strategy
// RQ8: current-value strategy keeps passing the signal
// RQ9: substitute strategy drives configured substitute value
// RQ10: last-valid strategy holds value before fault
// RQ11: inversion outputs the complement of processed signal
// RQ12: ON delay acts on rising changes, in ms
// RQ13: OFF delay postpones falling changes, in ms
// RQ14: invalid simulated value starts strategy too
// RQ15: successful exchange clears failures and watchdog time
// RQ16: errors gone, processed signal is driven again
`timescale 1ns/10ps
module dout_channels
  import dout_pkg::*;
#(
  parameter int MS_LEN = CYC_PER_MS,
  parameter int WD_LEN = WD_CYCLES
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     module_active,
  input  wire link_s                    link,
  input  wire chan_cfg_s [NUM_CH-1:0]   cfg,
  output logic [NUM_CH-1:0]             out_drive,
  output logic [NUM_CH-1:0]             line_fault,
  output logic [NUM_CH-1:0]             err_active,
  output logic                          wd_off
);
  localparam int MW = $clog2(MS_LEN + 1);

  logic [MW-1:0]     ms_cnt;
  logic              ms_tick;
  logic              wd_trip;
  logic [NUM_CH-1:0] src;
  logic [NUM_CH-1:0] src_bad;
  logic [NUM_CH-1:0] err_now;
  logic [NUM_CH-1:0] chosen;
  logic [NUM_CH-1:0] proc_val;
  logic [NUM_CH-1:0] last_valid;
  logic [NUM_CH-1:0] delayed;

  // selects the signal that an error condition leaves on the channel
  function automatic logic pick(input strategy_e s, input logic cur, input logic sub,
                                input logic last);
    logic r;
    r = cur;
    unique case (s)
      STRAT_CURRENT: r = cur;
      STRAT_SUBST:   r = sub;
      STRAT_LAST:    r = last;
      default:       r = sub;
    endcase
    return r;
  endfunction

  // millisecond time base for the delays
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ms_cnt  <= '0;
      ms_tick <= 1'b0;
    end else if (ms_cnt == MW'(MS_LEN - 1)) begin
      ms_cnt  <= '0;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt  <= ms_cnt + MW'(1);
      ms_tick <= 1'b0;
    end
  end

  wd_monitor #(
    .WD_LEN (WD_LEN)
  ) u_wd (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .xfer_ok   (link.xfer_ok),
    .xfer_fail (link.xfer_fail),
    .tripped   (wd_trip)
  );

  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      // source selection by operating mode
      always_comb begin
        if (cfg[i].sim_mode) begin
          src[i]     = cfg[i].sim_value;   // RQ5
          src_bad[i] = cfg[i].sim_invalid; // RQ14
        end else begin
          src[i]     = link.value[i];      // RQ4
          src_bad[i] = link.invalid[i];
        end
      end

      // only communication errors and invalid data count; there is no line fault input
      assign err_now[i] = wd_trip | link.bus_down | src_bad[i]; // RQ6 RQ7

      assign chosen[i] = err_now[i] ? pick(cfg[i].strategy, src[i], cfg[i].subst_value, last_valid[i])
                                    : src[i]; // RQ8 RQ9 RQ16

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          last_valid[i] <= RST_LAST;
        end else if (!err_now[i]) begin
          last_valid[i] <= src[i]; // RQ10
        end
      end

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          proc_val[i] <= RST_OUT;
        end else begin
          proc_val[i] <= chosen[i] ^ cfg[i].invert; // RQ11
        end
      end

      edge_delay u_dly (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ms_tick (ms_tick),
        .din     (proc_val[i]),
        .on_ms   (cfg[i].on_ms),
        .off_ms  (cfg[i].off_ms),
        .dout    (delayed[i])
      );

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          out_drive[i] <= RST_OUT;
        end else if (!module_active) begin
          out_drive[i] <= OFF_LEVEL; // RQ3
        end else if (wd_trip) begin
          out_drive[i] <= OFF_LEVEL; // RQ2
        end else begin
          out_drive[i] <= delayed[i];
        end
      end

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          err_active[i] <= 1'b0;
        end else begin
          err_active[i] <= err_now[i];
        end
      end

      always_ff @(posedge sys_clk) begin
        line_fault[i] <= NO_LINE_ERR; // RQ1
      end

      property p_normal;
        @(posedge sys_clk) disable iff (rst)
          (!cfg[i].sim_mode && !err_now[i]) |=> proc_val[i] == ($past(link.value[i]) ^ $past(cfg[i].invert));
      endproperty
      a_normal: assert property (p_normal) else $error("normal mode did not pass bus value"); // RQ4

      property p_sim;
        @(posedge sys_clk) disable iff (rst)
          (cfg[i].sim_mode && !err_now[i]) |=> proc_val[i] == ($past(cfg[i].sim_value) ^ $past(cfg[i].invert));
      endproperty
      a_sim: assert property (p_sim) else $error("simulation mode did not pass simulated value"); // RQ5

      property p_sim_invalid;
        @(posedge sys_clk) disable iff (rst)
          (cfg[i].sim_mode && cfg[i].sim_invalid) |=> err_active[i];
      endproperty
      a_sim_invalid: assert property (p_sim_invalid) else $error("invalid simulated value gave no error"); // RQ14

      property p_subst;
        @(posedge sys_clk) disable iff (rst)
          (err_now[i] && cfg[i].strategy == STRAT_SUBST)
            |=> proc_val[i] == ($past(cfg[i].subst_value) ^ $past(cfg[i].invert));
      endproperty
      a_subst: assert property (p_subst) else $error("substitute value not applied"); // RQ9

      property p_current;
        @(posedge sys_clk) disable iff (rst)
          (err_now[i] && cfg[i].strategy == STRAT_CURRENT) |=> proc_val[i] == ($past(src[i]) ^ $past(cfg[i].invert));
      endproperty
      a_current: assert property (p_current) else $error("current value not kept under error"); // RQ8

      property p_last;
        @(posedge sys_clk) disable iff (rst)
          (!err_now[i] ##1 err_now[i] && cfg[i].strategy == STRAT_LAST && !cfg[i].invert)
            |=> proc_val[i] == $past(src[i], 2);
      endproperty
      a_last: assert property (p_last) else $error("last valid value not held"); // RQ10

      property p_inactive;
        @(posedge sys_clk) disable iff (rst)
          !module_active |=> out_drive[i] == OFF_LEVEL;
      endproperty
      a_inactive: assert property (p_inactive) else $error("inactive channel driven"); // RQ3

      property p_wd_off;
        @(posedge sys_clk) disable iff (rst)
          wd_trip |=> out_drive[i] == OFF_LEVEL && err_active[i];
      endproperty
      a_wd_off: assert property (p_wd_off) else $error("watchdog did not switch output off"); // RQ2

      property p_no_line_fault;
        @(posedge sys_clk) disable iff (rst)
          1'b1 |=> line_fault[i] == NO_LINE_ERR;
      endproperty
      a_no_line_fault: assert property (p_no_line_fault) else $error("line fault reported"); // RQ1

      property p_err_cause;
        @(posedge sys_clk) disable iff (rst)
          err_active[i] |-> $past(wd_trip) || $past(link.bus_down) || $past(src_bad[i]);
      endproperty
      a_err_cause: assert property (p_err_cause) else $error("error raised without communication cause"); // RQ7

      property p_recover;
        @(posedge sys_clk) disable iff (rst)
          ($past(err_now[i]) && !err_now[i]) |=> proc_val[i] == ($past(src[i]) ^ $past(cfg[i].invert)) && !err_active[i];
      endproperty
      a_recover: assert property (p_recover) else $error("channel did not resume after error"); // RQ16

      property p_bus_err;
        @(posedge sys_clk) disable iff (rst)
          link.bus_down |=> err_active[i];
      endproperty
      a_bus_err: assert property (p_bus_err) else $error("bus failure gave no error"); // RQ6

      property p_invalid_err;
        @(posedge sys_clk) disable iff (rst)
          (!cfg[i].sim_mode && link.invalid[i]) |=> err_active[i];
      endproperty
      a_invalid_err: assert property (p_invalid_err) else $error("invalid bus value gave no error"); // RQ6

      property p_err_flag;
        @(posedge sys_clk) disable iff (rst)
          1'b1 |=> err_active[i] == $past(err_now[i]);
      endproperty
      a_err_flag: assert property (p_err_flag) else $error("error flag does not follow error condition"); // RQ6

      property p_last_track;
        @(posedge sys_clk) disable iff (rst)
          !err_now[i] |=> last_valid[i] == $past(src[i]);
      endproperty
      a_last_track: assert property (p_last_track) else $error("last valid value not tracking source"); // RQ10

      property p_last_freeze;
        @(posedge sys_clk) disable iff (rst)
          err_now[i] |=> last_valid[i] == $past(last_valid[i]);
      endproperty
      a_last_freeze: assert property (p_last_freeze) else $error("last valid value changed under error"); // RQ10

      property p_spare_code;
        @(posedge sys_clk) disable iff (rst)
          (err_now[i] && cfg[i].strategy == strategy_e'(2'h3))
            |=> proc_val[i] == ($past(cfg[i].subst_value) ^ $past(cfg[i].invert));
      endproperty
      a_spare_code: assert property (p_spare_code) else $error("spare strategy code not substituting"); // RQ9

      property p_pass_out;
        @(posedge sys_clk) disable iff (rst)
          (module_active && !wd_trip) |=> out_drive[i] == $past(delayed[i]);
      endproperty
      a_pass_out: assert property (p_pass_out) else $error("delayed value not driven to output"); // RQ16
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wd_off <= 1'b0;
    end else begin
      wd_off <= wd_trip; // RQ2
    end
  end

  property p_invert;
    @(posedge sys_clk) disable iff (rst)
      (!err_now[0] && cfg[0].invert) |=> proc_val[0] == !$past(src[0]);
  endproperty
  a_invert: assert property (p_invert) else $error("inversion not applied"); // RQ11

  property p_tick;
    @(posedge sys_clk) disable iff (rst)
      ms_tick |=> !ms_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("millisecond tick longer than one cycle");

  property p_wd_flag;
    @(posedge sys_clk) disable iff (rst)
      1'b1 |=> wd_off == $past(wd_trip);
  endproperty
  a_wd_flag: assert property (p_wd_flag) else $error("watchdog flag does not follow trip"); // RQ2

  property p_tick_phase;
    @(posedge sys_clk) disable iff (rst)
      ms_tick |-> ms_cnt == '0;
  endproperty
  a_tick_phase: assert property (p_tick_phase) else $error("millisecond tick out of phase with counter"); // RQ12

  c_sim:   cover property (@(posedge sys_clk) disable iff (rst) cfg[0].sim_mode && !err_now[0] ##1 out_drive[0]);
  c_subst: cover property (@(posedge sys_clk) disable iff (rst) link.invalid[0] && cfg[0].strategy == STRAT_SUBST);
  c_last:  cover property (@(posedge sys_clk) disable iff (rst) link.bus_down && cfg[1].strategy == STRAT_LAST);
  c_trip:  cover property (@(posedge sys_clk) disable iff (rst) $rose(wd_off));

endmodule

// file: common/dout_pkg.sv
// dout_pkg: constants, types and carriers of the eight-channel digital output logic.
// assumes one 50 MHz clock shared by the block and the communication unit logic.
package dout_pkg;

  localparam int NUM_CH       = 8;
  localparam int CLK_HZ       = 50_000_000;
  localparam int MS_PER_S     = 1000;
  localparam int CYC_PER_MS   = CLK_HZ / MS_PER_S;
  localparam int WD_TIME_MS   = 500;
  localparam int WD_CYCLES    = WD_TIME_MS * CYC_PER_MS;
  localparam int FAIL_LIMIT   = 3;
  localparam int DELAY_W      = 16;

  localparam logic RST_OUT     = 1'b0;
  localparam logic RST_LAST    = 1'b0;
  localparam logic NO_LINE_ERR = 1'b0;
  localparam logic OFF_LEVEL   = 1'b0;

  // error strategy codes
  typedef enum logic [1:0] {
    STRAT_CURRENT = 2'h0,
    STRAT_SUBST   = 2'h1,
    STRAT_LAST    = 2'h2
  } strategy_e;

  // watchdog states, gray along run -> armed -> tripped
  typedef enum logic [1:0] {
    WD_RUN     = 2'h0,
    WD_ARMED   = 2'h1,
    WD_TRIPPED = 2'h3
  } wd_state_e;

  // one exchange with the communication unit
  typedef struct packed {
    logic              xfer_ok;
    logic              xfer_fail;
    logic              bus_down;
    logic [NUM_CH-1:0] value;
    logic [NUM_CH-1:0] invalid;
  } link_s;

  // per-channel configuration
  typedef struct packed {
    logic               sim_mode;
    logic               invert;
    strategy_e          strategy;
    logic               subst_value;
    logic               sim_value;
    logic               sim_invalid;
    logic [DELAY_W-1:0] on_ms;
    logic [DELAY_W-1:0] off_ms;
  } chan_cfg_s;

endpackage

// file: rtl/wd_monitor.sv
// wd_monitor: counts failed exchanges and trips after the grace time.
// assumes xfer_ok and xfer_fail are one-cycle pulses on sys_clk.
`timescale 1ns/10ps
module wd_monitor
  import dout_pkg::*;
#(
  parameter int WD_LEN = WD_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic xfer_ok,
  input  wire logic xfer_fail,
  output logic      tripped
);
  localparam int TW = $clog2(WD_LEN + 1);

  wd_state_e    state;
  logic [1:0]   fails;
  logic [TW-1:0] tmr;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fails <= 2'h0;
    end else if (xfer_ok) begin
      fails <= 2'h0; // RQ15
    end else if (xfer_fail && fails != 2'(FAIL_LIMIT)) begin
      fails <= fails + 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= WD_RUN;
      tmr   <= '0;
    end else if (xfer_ok) begin
      state <= WD_RUN; // RQ15
      tmr   <= '0;
    end else begin
      unique case (state)
        WD_RUN: begin
          if (xfer_fail && fails == 2'(FAIL_LIMIT - 1)) begin
            state <= WD_ARMED; // RQ2
          end
        end
        WD_ARMED: begin
          if (tmr == TW'(WD_LEN - 1)) begin
            state <= WD_TRIPPED; // RQ2
          end else begin
            tmr <= tmr + TW'(1);
          end
        end
        WD_TRIPPED: state <= WD_TRIPPED;
        default:    state <= WD_RUN;
      endcase
    end
  end

  assign tripped = (state == WD_TRIPPED);

  property p_ok_clears;
    @(posedge sys_clk) disable iff (rst)
      xfer_ok |=> (fails == 2'h0) && !tripped;
  endproperty
  a_ok_clears: assert property (p_ok_clears) else $error("success did not clear watchdog"); // RQ15

  property p_trip_time;
    @(posedge sys_clk) disable iff (rst)
      (state == WD_ARMED && tmr == TW'(WD_LEN - 1) && !xfer_ok) |=> tripped;
  endproperty
  a_trip_time: assert property (p_trip_time) else $error("watchdog did not trip at end of grace time"); // RQ2

  property p_third_fail;
    @(posedge sys_clk) disable iff (rst)
      (state == WD_RUN && fails == 2'h2 && xfer_fail && !xfer_ok) |=> state == WD_ARMED && tmr == '0;
  endproperty
  a_third_fail: assert property (p_third_fail) else $error("third failure did not arm watchdog"); // RQ2

endmodule

// file: rtl/edge_delay.sv
// edge_delay: ON delay on rising changes, OFF delay on falling changes, in ms ticks.
// assumes ms_tick is a one-cycle pulse once per millisecond.
`timescale 1ns/10ps
module edge_delay
  import dout_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               ms_tick,
  input  wire logic               din,
  input  wire logic [DELAY_W-1:0] on_ms,
  input  wire logic [DELAY_W-1:0] off_ms,
  output logic                    dout
);
  logic [DELAY_W-1:0] cnt;
  logic [DELAY_W-1:0] target;

  // a change that goes back before cnt reaches its delay in ms ticks never reaches dout
  assign target = din ? on_ms : off_ms;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dout <= RST_OUT;
      cnt  <= '0;
    end else if (din == dout) begin
      cnt <= '0;
    end else if (cnt >= target) begin
      dout <= din; // RQ12 RQ13
      cnt  <= '0;
    end else if (ms_tick) begin
      cnt <= cnt + DELAY_W'(1);
    end
  end

  property p_on_hold;
    @(posedge sys_clk) disable iff (rst)
      (!dout && din && cnt < on_ms) |=> !dout;
  endproperty
  a_on_hold: assert property (p_on_hold) else $error("output rose before on delay"); // RQ12

  property p_off_hold;
    @(posedge sys_clk) disable iff (rst)
      (dout && !din && cnt < off_ms) |=> dout;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("output fell before off delay"); // RQ13

  property p_settle;
    @(posedge sys_clk) disable iff (rst)
      (din != dout && cnt >= target) |=> dout == $past(din);
  endproperty
  a_settle: assert property (p_settle) else $error("output missed change after delay"); // RQ12

endmodule

// file: bench/comm_unit_model.sv
// comm_unit_model: communication unit side of the backplane link.
// assumes the bench calls its tasks from one process; link changes on the falling edge.
`timescale 1ns/10ps
module comm_unit_model
  import dout_pkg::*;
(
  input  wire logic sys_clk,
  output link_s     link
);
  initial begin
    link = '0;
  end

  // output values, their invalid flags and the bus failure level, held until changed
  task automatic set_data(input logic [NUM_CH-1:0] v, input logic [NUM_CH-1:0] inv, input logic dn);
    @(negedge sys_clk);
    link.value    = v;
    link.invalid  = inv;
    link.bus_down = dn;
  endtask

  // one exchange attempt after gap idle cycles, reported as a one-cycle pulse
  task automatic exchange(input logic ok, input int gap);
    repeat (gap) @(negedge sys_clk);
    @(negedge sys_clk);
    link.xfer_ok   = ok;
    link.xfer_fail = !ok;
    @(negedge sys_clk);
    link.xfer_ok   = 1'b0;
    link.xfer_fail = 1'b0;
  endtask
endmodule

// file: bench/digital_output_channel_logic_tb_top.sv
// digital_output_channel_logic_tb_top: self-checking bench of dout_channels.
// assumes shortened ms and watchdog lengths; inputs change on the falling edge.
`timescale 1ns/10ps
module digital_output_channel_logic_tb_top
  import dout_pkg::*;
;
  localparam int MS_T = 10;
  localparam int WD_T = 50;

  logic                   sys_clk;
  logic                   rst;
  logic                   module_active;
  logic                   nact;
  link_s                  link;
  chan_cfg_s [NUM_CH-1:0] cfg;
  chan_cfg_s [NUM_CH-1:0] ncfg;
  logic [NUM_CH-1:0]      out_drive;
  logic [NUM_CH-1:0]      line_fault;
  logic [NUM_CH-1:0]      err_active;
  logic                   wd_off;
  logic [NUM_CH-1:0]      last_ok;
  int                     miscompares;
  int                     n_checks;
  int                     hits;

  dout_channels #(.MS_LEN(MS_T), .WD_LEN(WD_T)) u_dout_channels (
    .sys_clk(sys_clk), .rst(rst), .module_active(module_active), .link(link), .cfg(cfg),
    .out_drive(out_drive), .line_fault(line_fault), .err_active(err_active), .wd_off(wd_off));

  comm_unit_model u_comm_unit_model (.sys_clk(sys_clk), .link(link));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk8(input logic [NUM_CH-1:0] got, input logic [NUM_CH-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t vector got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t watchdog flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic hold_chk(input int n, input logic [NUM_CH-1:0] exp);
    repeat (n) begin
      @(negedge sys_clk);
      chk8(out_drive, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [NUM_CH-1:0] src_of(input logic [NUM_CH-1:0] v);
    for (int i = 0; i < NUM_CH; i++) begin
      src_of[i] = cfg[i].sim_mode ? cfg[i].sim_value : v[i];
    end
  endfunction

  function automatic logic [NUM_CH-1:0] bad_of(input logic [NUM_CH-1:0] inv, input logic dn);
    for (int i = 0; i < NUM_CH; i++) begin
      bad_of[i] = dn | (cfg[i].sim_mode ? cfg[i].sim_invalid : inv[i]);
    end
  endfunction

  function automatic logic [NUM_CH-1:0] drive_of(input logic [NUM_CH-1:0] s, input logic [NUM_CH-1:0] b);
    for (int i = 0; i < NUM_CH; i++) begin
      case (cfg[i].strategy)
        STRAT_CURRENT: drive_of[i] = s[i];
        STRAT_LAST:    drive_of[i] = b[i] ? last_ok[i] : s[i];
        default:       drive_of[i] = b[i] ? cfg[i].subst_value : s[i];
      endcase
      drive_of[i] = module_active & (drive_of[i] ^ cfg[i].invert);
    end
  endfunction

  // drive one settled state and compare once the zero-delay path has settled
  task automatic apply(input logic [NUM_CH-1:0] v, input logic [NUM_CH-1:0] inv, input logic dn);
    logic [NUM_CH-1:0] s;
    logic [NUM_CH-1:0] b;
    u_comm_unit_model.set_data(v, inv, dn);
    cfg           = ncfg;
    module_active = nact;
    s = src_of(v);
    b = bad_of(inv, dn);
    cyc(5);
    chk8(out_drive, drive_of(s, b));
    chk8(err_active, b);
    chk8(line_fault, 8'h00);
    chk1(wd_off, 1'b0);
    last_ok = (last_ok & b) | (s & ~b);
  endtask

  initial begin
    rst = 1'b1;
    module_active = 1'b1;
    nact = 1'b1;
    cfg = '0;
    ncfg = '0;
    last_ok = '0;
    miscompares = 0;
    n_checks = 0;
    void'($urandom(32'hBC5F));
    cyc(16);
    rst = 1'b0;
    apply(8'h00, 8'h00, 1'b0);
    // delays of 3 ms on and 2 ms off on every channel
    for (int i = 0; i < NUM_CH; i++) begin
      cfg[i].on_ms  = 16'h0003;
      cfg[i].off_ms = 16'h0002;
    end
    u_comm_unit_model.set_data(8'hFF, 8'h00, 1'b0);
    hold_chk(10, 8'h00);
    u_comm_unit_model.set_data(8'h00, 8'h00, 1'b0);
    hold_chk(35, 8'h00);
    u_comm_unit_model.set_data(8'hFF, 8'h00, 1'b0);
    hold_chk(18, 8'h00);
    cyc(18);
    chk8(out_drive, 8'hFF);
    u_comm_unit_model.set_data(8'h00, 8'h00, 1'b0);
    cyc(5);
    u_comm_unit_model.set_data(8'hFF, 8'h00, 1'b0);
    hold_chk(30, 8'hFF);
    u_comm_unit_model.set_data(8'h00, 8'h00, 1'b0);
    hold_chk(8, 8'hFF);
    cyc(18);
    chk8(out_drive, 8'h00);
    apply(8'hA5, 8'h00, 1'b0);
    $display("test delays done");
    // three failed exchanges back to back, then the grace time
    for (int k = 0; k < 3; k++) u_comm_unit_model.exchange(1'b0, 0);
    hits = 0;
    repeat (WD_T - 5) begin
      @(negedge sys_clk);
      hits += wd_off;
    end
    chk1(hits != 0, 1'b0);
    for (int k = 0; k < 15 && wd_off !== 1'b1; k++) cyc(1);
    chk1(wd_off, 1'b1);
    if (wd_off !== 1'b1) begin
      stop_test();
    end
    chk8(out_drive, 8'h00);
    chk8(err_active, 8'hFF);
    u_comm_unit_model.exchange(1'b1, 2);
    cyc(3);
    chk1(wd_off, 1'b0);
    apply(8'hA5, 8'h00, 1'b0);
    $display("test watchdog done");
    // a success in between restarts the failure count
    u_comm_unit_model.exchange(1'b0, 0);
    u_comm_unit_model.exchange(1'b0, 3);
    u_comm_unit_model.exchange(1'b1, 0);
    u_comm_unit_model.exchange(1'b0, 1);
    u_comm_unit_model.exchange(1'b0, 0);
    hits = 0;
    repeat (WD_T + 20) begin
      @(negedge sys_clk);
      hits += wd_off;
    end
    chk1(hits != 0, 1'b0);
    $display("test restart done");
    // first eight steps walk every strategy code in both modes with invalid data
    for (int k = 0; k < 200; k++) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ncfg[i] = '0;
        ncfg[i].sim_mode    = (k < 8) ? k[0] : 1'($urandom);
        ncfg[i].invert      = 1'($urandom);
        ncfg[i].strategy    = strategy_e'((k < 8) ? k[2:1] : 2'($urandom));
        ncfg[i].subst_value = 1'($urandom);
        ncfg[i].sim_value   = 1'($urandom);
        ncfg[i].sim_invalid = (k < 8) || ($urandom % 4 == 0);
      end
      nact = ($urandom % 10) != 0;
      if (k < 8) begin
        apply(8'($urandom), 8'hFF, 1'b0);
      end else begin
        apply(8'($urandom), 8'($urandom & $urandom & $urandom), ($urandom % 8) == 0);
      end
    end
    $display("test random done");
    stop_test();
  end
endmodule
